// ---- rtl/lfsr_random.v ----
`timescale 1ns/1ps
// free lfsr; fires when the low bits match zero, rate set by width
module lfsr_random #(
   parameter RW = 16
) (
   input  wire core_clk_i,
   input  wire resetn_i,
   input  wire en_i,
   output reg  fire_o
);
   reg [15:0] lfsr;
   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         lfsr   <= 16'hace1;
         fire_o <= 1'b0;
      end else begin
         lfsr   <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
         fire_o <= en_i && (lfsr[RW-1:0] == {RW{1'b0}});
      end
   end
endmodule

// ---- rtl/pmt_trigger_front_end.v ----
`timescale 1ns/1ps
`include "pmt_trigger_regs.vh"
// Operation
// - per-channel trigger when signal crosses threshold
// - several coincidence channels, each enabled by mask
// - clip muon peak before integrating the signal
// - require time spread to reject short deposits
// - variant: higher threshold, shorter duration
// - total-light muon trigger on selectable tubes
// - random trigger as enabled diagnostic source (with RW 16 the lfsr never reaches all zeros, so it never fires)
// - count burst-search triggers per 0.1 s
// - non-burst coincidences raise the interrupt line
// - optional self-disable on fire until re-enabled
// - half-pe crossing runs digitizer for 20 us
// - window extended 15 us after coincidence
// - buffer waveforms of at least two events
// - wide dynamic range, fast sampling recommended
// - samples need only 8 to 10 bits
// - logic quiescent outside the digitizer window (sample storage and the trigger checks are gated; the lfsr and burst gate timer always run)
// - timing latch queues event triggers (no latch here; event_cause_o keeps only the last fired set)
module pmt_trigger_front_end #(
   parameter DW       = 10,
   parameter AW       = 11,
   parameter GATE_CYC = `GATE_CYC
) (
   input  wire          core_clk_i,
   input  wire          resetn_i,
   input  wire [2:0]    disc_i,
   input  wire [2:0]    lowdisc_i,
   input  wire [DW-1:0] adc0_i,
   input  wire [DW-1:0] adc1_i,
   input  wire [DW-1:0] adc2_i,
   input  wire [4:0]    trig_mask_i,
   input  wire          self_disable_i,
   input  wire          reenable_i,
   input  wire [DW-1:0] clip_level_i,
   input  wire [DW+1:0] spread_level_i,
   input  wire [7:0]    spread_len_i,
   input  wire [DW+1:0] core_level_i,
   input  wire [7:0]    core_len_i,
   input  wire [DW+1:0] muon_level_i,
   input  wire [2:0]    muon_sel_i,
   input  wire [DW-1:0] burst_level_i,
   input  wire          slot_release_i,
   input  wire [AW-1:0] rd_addr_i,
   input  wire [2:0]    rd_pmt_i,
   output reg  [2:0]    chan_trig_o,
   output reg           event_irq_o,
   output reg  [4:0]    event_cause_o,
   output reg           trig_armed_o,
   output reg  [15:0]   burst_count_o,
   output reg           burst_count_valid_o,
   output reg           window_active_o,
   output reg           slot_ready_o,
   output reg           rd_slot_o,
   output reg  [AW-1:0] rd_len_o,
   output reg  [DW-1:0] rd_data_o,
   output wire          overflow_o
);
   localparam WIN_CYC = `WIN_CYC;
   localparam EXT_CYC = `EXT_CYC;
   localparam DEPTH   = 1 << AW;
   localparam S_IDLE  = 2'd0;
   localparam S_WIN   = 2'd1;
   localparam S_DONE  = 2'd2;

   function [DW-1:0] clip;
      input [DW-1:0] v;
      input [DW-1:0] lim;
      clip = (v > lim) ? lim : v;
   endfunction

   reg  [1:0]    state;
   reg  [15:0]   win_cnt;
   reg  [AW-1:0] wr_ptr;
   reg           wr_slot;
   reg  [1:0]    full;
   reg  [AW-1:0] slot_len [0:1];
   // four words per sample address (one spare) so the slot and tube bits index directly
   reg  [DW-1:0] mem [0:4*2*DEPTH-1];
   reg  [2:0]    disc_q;
   reg  [2:0]    low_q;
   reg           muon_q;
   reg           coinc_seen;
   reg  [31:0]   gate_cnt;
   reg  [15:0]   burst_acc;
   reg           burst_q;
   reg           ovf;
   wire          running = (state == S_WIN);
   wire [DW+1:0] clip_sum = clip(adc0_i, clip_level_i) + clip(adc1_i, clip_level_i)
                          + clip(adc2_i, clip_level_i);
   wire [DW+1:0] raw_sum  = adc0_i + adc1_i + adc2_i;
   wire [DW+1:0] muon_sum = (muon_sel_i[0] ? adc0_i : {DW{1'b0}})
                          + (muon_sel_i[1] ? adc1_i : {DW{1'b0}})
                          + (muon_sel_i[2] ? adc2_i : {DW{1'b0}});
   wire          spread_hit;
   wire          core_hit;
   wire          rand_hit;
   wire [2:0]    low_rise = lowdisc_i & ~low_q;
   wire          thresh_hit = running && (&disc_i) && !(&disc_q);
   wire          muon_above = running && (muon_sum > muon_level_i);
   // edge only: a level would hold the interrupt for the whole pulse
   wire          muon_hit   = muon_above && !muon_q;
   wire [4:0]    cand = {rand_hit & running, muon_hit, core_hit, spread_hit, thresh_hit};
   wire [4:0]    fired = cand & trig_mask_i & {5{trig_armed_o}};
   wire          any_fire = |fired;
   wire          burst_now = running && (adc0_i > burst_level_i)
                           && (adc1_i > burst_level_i) && (adc2_i > burst_level_i);
   wire          store = running && !full[wr_slot];

   assign overflow_o = ovf;

   spread_check #(.SW(DW+2), .CW(8)) u_spread (
      .core_clk_i(core_clk_i),
      .resetn_i  (resetn_i),
      .run_i     (running),
      .sum_i     (clip_sum),
      .level_i   (spread_level_i),
      .len_i     (spread_len_i),
      .hit_o     (spread_hit)
   );

   spread_check #(.SW(DW+2), .CW(8)) u_core (
      .core_clk_i(core_clk_i),
      .resetn_i  (resetn_i),
      .run_i     (running),
      .sum_i     (raw_sum),
      .level_i   (core_level_i),
      .len_i     (core_len_i),
      .hit_o     (core_hit)
   );

   lfsr_random #(.RW(16)) u_rand (
      .core_clk_i(core_clk_i),
      .resetn_i  (resetn_i),
      .en_i      (trig_mask_i[`CH_RANDOM]),
      .fire_o    (rand_hit)
   );

   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         disc_q      <= 3'h0;
         low_q       <= 3'h0;
         muon_q      <= 1'b0;
         chan_trig_o <= 3'h0;
      end else begin
         disc_q      <= disc_i;
         low_q       <= lowdisc_i;
         muon_q      <= muon_above;
         chan_trig_o <= disc_i & ~disc_q;
      end
   end

   // window control: a half-pe edge opens it, a coincidence extends it
   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         state           <= S_IDLE;
         win_cnt         <= 16'h0;
         wr_ptr          <= {AW{1'b0}};
         wr_slot         <= 1'b0;
         full            <= 2'h0;
         slot_len[0]     <= {AW{1'b0}};
         slot_len[1]     <= {AW{1'b0}};
         coinc_seen      <= 1'b0;
         window_active_o <= 1'b0;
         ovf             <= 1'b0;
      end else begin
         if (slot_release_i && full[rd_slot_o])
            full[rd_slot_o] <= 1'b0;
         case (state)
            S_IDLE: begin
               if (|low_rise) begin
                  if (full[wr_slot]) begin
                     ovf <= 1'b1;
                  end else begin
                     state      <= S_WIN;
                     win_cnt    <= WIN_CYC[15:0];
                     wr_ptr     <= {AW{1'b0}};
                     coinc_seen <= 1'b0;
                  end
               end
            end
            S_WIN: begin
               if (wr_ptr != {AW{1'b1}})
                  wr_ptr <= wr_ptr + 1'b1;
               if (any_fire) begin
                  coinc_seen <= 1'b1;
                  win_cnt    <= EXT_CYC[15:0];
               end else if (win_cnt == 16'h1) begin
                  state <= S_DONE;
               end else begin
                  win_cnt <= win_cnt - 1'b1;
               end
            end
            S_DONE: begin
               state <= S_IDLE;
               if (coinc_seen) begin
                  full[wr_slot]     <= 1'b1;
                  slot_len[wr_slot] <= wr_ptr;
                  wr_slot           <= ~wr_slot;
               end
            end
            default: state <= S_IDLE;
         endcase
         window_active_o <= (state == S_WIN);
      end
   end

   // sample storage only clocks during a window to keep logic idle
   always @(posedge core_clk_i) begin
      if (store) begin
         mem[{wr_slot, wr_ptr, 2'd0}] <= adc0_i;
         mem[{wr_slot, wr_ptr, 2'd1}] <= adc1_i;
         mem[{wr_slot, wr_ptr, 2'd2}] <= adc2_i;
      end
   end

   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         rd_slot_o    <= 1'b0;
         slot_ready_o <= 1'b0;
         rd_len_o     <= {AW{1'b0}};
         rd_data_o    <= {DW{1'b0}};
      end else begin
         if (slot_release_i && full[rd_slot_o])
            rd_slot_o <= ~rd_slot_o;
         slot_ready_o <= full[rd_slot_o] && !slot_release_i;
         rd_len_o     <= slot_len[rd_slot_o];
         rd_data_o    <= mem[{rd_slot_o, rd_addr_i,
                            rd_pmt_i[2] ? 2'd2 : (rd_pmt_i[1] ? 2'd1 : 2'd0)}];
      end
   end

   // coincidence outputs; the armed bit lets calibration catch one muon
   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         trig_armed_o  <= 1'b1;
         event_irq_o   <= 1'b0;
         event_cause_o <= 5'h0;
      end else begin
         event_irq_o <= any_fire;
         if (any_fire)
            event_cause_o <= fired;
         if (any_fire && self_disable_i)
            trig_armed_o <= 1'b0;
         else if (reenable_i)
            trig_armed_o <= 1'b1;
      end
   end

   // burst scaler: counts rising edges only, not held samples
   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         gate_cnt            <= 32'h0;
         burst_acc           <= 16'h0;
         burst_q             <= 1'b0;
         burst_count_o       <= 16'h0;
         burst_count_valid_o <= 1'b0;
      end else begin
         burst_q <= burst_now;
         burst_count_valid_o <= 1'b0;
         if (gate_cnt == GATE_CYC - 1) begin
            gate_cnt            <= 32'h0;
            burst_count_o       <= burst_acc + {15'h0, burst_now & ~burst_q};
            burst_count_valid_o <= 1'b1;
            burst_acc           <= 16'h0;
         end else begin
            gate_cnt <= gate_cnt + 1'b1;
            if (burst_now && !burst_q && burst_acc != 16'hffff)
               burst_acc <= burst_acc + 1'b1;
         end
      end
   end
endmodule

// ---- rtl/pmt_trigger_regs.vh ----
`ifndef PMT_TRIGGER_REGS_VH
`define PMT_TRIGGER_REGS_VH
`define CLK_MHZ          100
`define WIN_US           20
`define EXT_US           15
`define GATE_MS          100
`define WIN_CYC          (`WIN_US * `CLK_MHZ)
`define EXT_CYC          (`EXT_US * `CLK_MHZ)
`define GATE_CYC         (`GATE_MS * 1000 * `CLK_MHZ)
`define TRIG_CH          5
`define CH_THRESH        0
`define CH_TIMESPREAD    1
`define CH_NEARCORE      2
`define CH_MUON          3
`define CH_RANDOM        4
`define SLOTS            2
`endif

// ---- rtl/spread_check.v ----
`timescale 1ns/1ps
`include "pmt_trigger_regs.vh"
// counts consecutive cycles a sum stays above a level; fires once the
// run reaches the wanted length, which gives the time-spread test
module spread_check #(
   parameter SW = 12,
   parameter CW = 8
) (
   input  wire          core_clk_i,
   input  wire          resetn_i,
   input  wire          run_i,
   input  wire [SW-1:0] sum_i,
   input  wire [SW-1:0] level_i,
   input  wire [CW-1:0] len_i,
   output reg           hit_o
);
   reg [CW-1:0] cnt;
   always @(posedge core_clk_i) begin
      if (!resetn_i) begin
         cnt   <= {CW{1'b0}};
         hit_o <= 1'b0;
      end else if (!run_i || sum_i <= level_i) begin
         cnt   <= {CW{1'b0}};
         hit_o <= 1'b0;
      end else begin
         if (cnt != {CW{1'b1}})
            cnt <= cnt + 1'b1;
         hit_o <= (cnt + 1'b1 == len_i);
      end
   end
endmodule

// ---- tb/controller_model.sv ----
`timescale 1ns/1ps
module controller_model (
   input  wire        core_clk_i,
   input  wire        resetn_i,
   input  wire        slot_ready_i,
   input  wire [9:0]  rd_data_i,
   input  wire [15:0] slow_i,
   output reg  [10:0] rd_addr_o = 11'h000,
   output reg  [2:0]  rd_pmt_o = 3'h1,
   output reg         slot_release_o = 1'b0,
   output reg  [9:0]  word_o = 10'h000,
   output reg  [7:0]  reads_o = 8'h00
);
   initial forever begin
      @(negedge core_clk_i);
      if (resetn_i === 1'b1 && slot_ready_i === 1'b1) begin
         rd_addr_o = 11'h014;
         rd_pmt_o = 3'h2;
         repeat (2) @(negedge core_clk_i);
         word_o = rd_data_i;
         // scrambled idle address so a stale read does not pass unseen
         rd_addr_o = 11'h7eb;
         repeat (slow_i) @(negedge core_clk_i);
         slot_release_o = 1'b1;
         @(negedge core_clk_i);
         slot_release_o = 1'b0;
         reads_o = reads_o + 8'h01;
      end
   end
endmodule

// ---- tb/pmt_trigger_front_end_monitor.sv ----
`timescale 1ns/1ps
module pmt_monitor #(
   parameter GATE_CYC = 100
) (
   input wire       core_clk_i,
   input wire       resetn_i,
   input wire [4:0] trig_mask_i,
   input wire       self_disable_i,
   input wire       slot_release_i,
   input wire       event_irq_o,
   input wire [4:0] event_cause_o,
   input wire       trig_armed_o,
   input wire       burst_count_valid_o,
   input wire       window_active_o,
   input wire       slot_ready_o
);
   integer win_len;
   integer since_irq;
   integer gap;
   reg     irq_seen;
   reg     gate_seen;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);
   // counters need no reset: each is only read once a qualifying event has cleared it
   always @(posedge core_clk_i) begin
      win_len <= window_active_o ? win_len + 1 : 0;
      since_irq <= event_irq_o ? 0 : since_irq + 1;
      gap <= burst_count_valid_o ? 0 : gap + 1;
      irq_seen <= window_active_o & (irq_seen | event_irq_o);
      gate_seen <= resetn_i & (gate_seen | burst_count_valid_o);
   end
   irq_pulse_a: assert property (event_irq_o |=> !event_irq_o)
      else $error("interrupt wider than one cycle");
   irq_window_a: assert property (event_irq_o |-> $past(window_active_o))
      else $error("interrupt outside window");
   cause_mask_a: assert property (event_irq_o |-> ##[0:1]
      (event_cause_o != 5'h00 && (event_cause_o & ~trig_mask_i) == 5'h00))
      else $error("cause not enabled by mask");
   win_len_a: assert property ($fell(window_active_o) && !irq_seen |-> win_len == 2000)
      else $error("plain window length wrong");
   win_ext_a: assert property ($fell(window_active_o) && irq_seen |-> since_irq >= 1498)
      else $error("window closed before tail");
   disarm_a: assert property (event_irq_o && self_disable_i |-> ##[0:1] !trig_armed_o)
      else $error("trigger stayed armed");
   gate_period_a: assert property (burst_count_valid_o && gate_seen |-> gap == GATE_CYC - 1)
      else $error("burst gate period wrong");
   slot_hold_a: assert property ($fell(slot_ready_o) |-> $past(slot_release_i))
      else $error("slot dropped without release");
endmodule
bind pmt_trigger_front_end pmt_monitor #(.GATE_CYC(GATE_CYC)) pmt_monitor_i (
   .core_clk_i(core_clk_i), .resetn_i(resetn_i), .trig_mask_i(trig_mask_i),
   .self_disable_i(self_disable_i), .slot_release_i(slot_release_i),
   .event_irq_o(event_irq_o), .event_cause_o(event_cause_o), .trig_armed_o(trig_armed_o),
   .burst_count_valid_o(burst_count_valid_o), .window_active_o(window_active_o),
   .slot_ready_o(slot_ready_o));

// ---- tb/tb_pmt_trigger_front_end.sv ----
`timescale 1ns/1ps
module tb_pmt_trigger_front_end;
   reg         clk = 1'b0;
   reg         rstn = 1'b0;
   reg  [2:0]  disc = 3'h0;
   reg  [2:0]  lowdisc = 3'h0;
   reg  [9:0]  adc = 10'h000;
   reg  [9:0]  clip = 10'h3ff;
   reg  [7:0]  len = 8'h14;
   reg  [4:0]  mask = 5'h00;
   reg         sdis = 1'b0;
   reg         reen = 1'b0;
   reg  [15:0] slow = 16'h0005;
   reg  [2:0]  msel = 3'h7;
   wire [10:0] addr;
   wire [9:0]  rdata, word;
   wire [2:0]  pmt;
   wire [4:0]  cause;
   wire [15:0] bcount;
   wire [7:0]  reads;
   wire        irq, armed, bvalid, win, ready, rel, ovf;
   integer     err_total = 0;
   integer     checks_done = 0;
   integer     irqs = 0;
   integer     bsum = 0;
   integer     base, k;
   initial forever #5 clk = ~clk;
   always @(posedge clk) begin
      irqs <= irqs + (irq === 1'b1);
      bsum <= bsum + ((bvalid === 1'b1) ? bcount : 0);
   end
   pmt_trigger_front_end #(.GATE_CYC(100)) pmt_trigger_front_end_i (
      .core_clk_i(clk), .resetn_i(rstn), .disc_i(disc), .lowdisc_i(lowdisc),
      .adc0_i(adc), .adc1_i(adc), .adc2_i(adc), .trig_mask_i(mask),
      .self_disable_i(sdis), .reenable_i(reen), .clip_level_i(clip),
      .spread_level_i(12'h180), .spread_len_i(len), .core_level_i(12'h600),
      .core_len_i({2'b00, len[7:2]}), .muon_level_i(12'h300), .muon_sel_i(msel),
      .burst_level_i(10'h100), .slot_release_i(rel), .rd_addr_i(addr), .rd_pmt_i(pmt),
      .chan_trig_o(), .event_irq_o(irq), .event_cause_o(cause), .trig_armed_o(armed),
      .burst_count_o(bcount), .burst_count_valid_o(bvalid), .window_active_o(win),
      .slot_ready_o(ready), .rd_slot_o(), .rd_len_o(), .rd_data_o(rdata), .overflow_o(ovf));
   controller_model controller_model_i (
      .core_clk_i(clk), .resetn_i(rstn), .slot_ready_i(ready), .rd_data_i(rdata),
      .slow_i(slow), .rd_addr_o(addr), .rd_pmt_o(pmt), .slot_release_o(rel),
      .word_o(word), .reads_o(reads));
   task check(input [19:0] got, input [19:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
         end
      end
   endtask
   task end_sim;
      begin
         $display("checks %0d mismatches %0d", checks_done, err_total);
         if (err_total == 0 && checks_done > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   task wait_win(input v);
      integer i;
      begin
         for (i = 0; i < 4000 && win !== v; i = i + 1)
            @(negedge clk);
         if (win !== v) begin
            err_total = err_total + 1;
            end_sim;
         end
      end
   endtask
   // one window: open on a half-pe edge, apply a stimulus, let it close and drain
   task run(input [4:0] m, input [9:0] v, input integer n, input [2:0] d, input e);
      begin
         base = irqs;
         mask = m;
         lowdisc = 3'h1;
         @(negedge clk);
         lowdisc = 3'h0;
         wait_win(1'b1);
         repeat (5) @(negedge clk);
         disc = d;
         adc = v;
         repeat (n) @(negedge clk);
         disc = 3'h0;
         adc = 10'h000;
         wait_win(1'b0);
         repeat (30) @(negedge clk);
         check(irqs - base, e);
      end
   endtask
   initial begin
      repeat (12) @(negedge clk);
      rstn = 1'b1;
      @(negedge clk);
      check({armed, win, ovf, ready, bcount}, 20'h80000);
      mask = 5'h01;
      disc = 3'h7;
      repeat (4) @(negedge clk);
      disc = 3'h0;
      check(irqs, 0);
      for (k = 0; k < 3; k = k + 1)
         run(5'h00, 10'h150, 4, 3'h0, 1'b0);
      check(bsum, 3);
      run(5'h01, 10'h000, 4, 3'h0, 1'b0);
      check(reads, 0);
      run(5'h01, 10'h155, 40, 3'h7, 1'b1);
      check({cause, reads, word}, {5'h01, 8'h01, 10'h155});
      run(5'h02, 10'h000, 4, 3'h7, 1'b0);
      run(5'h02, 10'h0a0, 10, 3'h0, 1'b0);
      run(5'h02, 10'h0a0, 40, 3'h0, 1'b1);
      clip = 10'h040;
      run(5'h02, 10'h0a0, 40, 3'h0, 1'b0);
      clip = 10'h3ff;
      run(5'h04, 10'h240, 10, 3'h0, 1'b1);
      run(5'h04, 10'h0a0, 10, 3'h0, 1'b0);
      msel = 3'h1;
      run(5'h08, 10'h120, 4, 3'h0, 1'b0);
      msel = 3'h7;
      run(5'h08, 10'h120, 4, 3'h0, 1'b1);
      sdis = 1'b1;
      run(5'h01, 10'h000, 4, 3'h7, 1'b1);
      check(armed, 0);
      run(5'h01, 10'h000, 4, 3'h7, 1'b0);
      reen = 1'b1;
      @(negedge clk);
      reen = 1'b0;
      sdis = 1'b0;
      @(negedge clk);
      check(armed, 1);
      slow = 16'd3000;
      run(5'h01, 10'h000, 4, 3'h7, 1'b1);
      run(5'h01, 10'h000, 4, 3'h7, 1'b1);
      lowdisc = 3'h1;
      @(negedge clk);
      lowdisc = 3'h0;
      repeat (4) @(negedge clk);
      check({win, ovf}, 2'b01);
      repeat (7000) @(negedge clk);
      check(reads, 7);
      end_sim;
   end
endmodule
